// File: pkg/jtbi_defs.svh
// Purpose: constants of the test access port block
// Assumes: included by bare name
// Notes: instruction codes are six bits wide
`ifndef JTBI_DEFS_SVH
`define JTBI_DEFS_SVH
`define JTBI_IR_W 6
`define JTBI_ID_W 32
`define JTBI_INS_EXTEST 6'h00
`define JTBI_INS_SAMPLE 6'h01
`define JTBI_INS_IDCODE 6'h02
`define JTBI_INS_HIGHZ 6'h03
`define JTBI_INS_CAPTURE 6'h2D
`define JTBI_INS_CLAMP 6'h3E
`define JTBI_INS_BYPASS 6'h3F
`define JTBI_ID_MARKER 1'h1
`define JTBI_RESET_TMS_CNT 3'h5
`endif

// File: pkg/jtbi_pkg.sv
// Purpose: types of the test access port block
// Assumes: nothing
// Notes: id word packed msb first
package jtbi_pkg;
  typedef enum logic [3:0] {
    JTBI_RESET = 4'h0, JTBI_IDLE = 4'h1, JTBI_SEL_DR = 4'h2, JTBI_CAP_DR = 4'h3,
    JTBI_SH_DR = 4'h4, JTBI_EX1_DR = 4'h5, JTBI_PA_DR = 4'h6, JTBI_EX2_DR = 4'h7,
    JTBI_UPD_DR = 4'h8, JTBI_SEL_IR = 4'h9, JTBI_CAP_IR = 4'hA, JTBI_SH_IR = 4'hB,
    JTBI_EX1_IR = 4'hC, JTBI_PA_IR = 4'hD, JTBI_EX2_IR = 4'hE, JTBI_UPD_IR = 4'hF
  } jtbi_state_t;
  typedef struct packed {
    logic [3:0] revision;
    logic [15:0] part_code;
    logic [10:0] maker_code_field;
    logic marker;
  } jtbi_id_t;
  typedef struct packed {
    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
  } jtbi_pins_t;
endpackage : jtbi_pkg

// File: rtl/jtbi_pin_sync.sv
// Purpose: two-stage sync of tap pins, tck edge detect
// Assumes: pins asynchronous to mclk
// Notes: first stage read only by second
`timescale 1ns/1ps
module jtbi_pin_sync
  import jtbi_pkg::*;
(
  input wire logic clk_in, // System clock
  input wire logic rst_n_in, // Reset, active low
  input wire logic tck_in, // Raw test clock
  input wire logic tms_in, // Raw mode select
  input wire logic tdi_in, // Raw data in
  input wire logic trst_n_in, // Raw test reset
  output jtbi_pins_t pins_out, // Synced pins and edges
  output logic trst_n_out // Synced test reset
);
  logic [3:0] meta_q, meta_d;
  logic [3:0] sync_q, sync_d;
  logic tck_old_q, tck_old_d;
  always_comb begin
    meta_d = {trst_n_in, tck_in, tms_in, tdi_in};
    sync_d = meta_q;
    tck_old_d = sync_q[2];
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
      tck_old_q <= 1'h0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      tck_old_q <= tck_old_d;
    end
  end
  always_comb begin
    pins_out.tck_rise = sync_q[2] & ~tck_old_q;
    pins_out.tck_fall = ~sync_q[2] & tck_old_q;
    pins_out.tms = sync_q[1];
    pins_out.tdi = sync_q[0];
    trst_n_out = sync_q[3];
  end
endmodule : jtbi_pin_sync

// File: rtl/jtbi_tap.sv
// Purpose: tap controller with bypass, id and instruction registers
// Assumes: tck sampled by mclk, well below mclk/4
// Notes: boundary chain lives outside; clamp and highz are flags out
//
// What this block does
// - Bypass puts a one-bit stage between data in and data out.
// - Capture-DR with bypass selected loads the bypass bit with zero.
// - Clamp holds chain outputs and routes data through bypass.
// - Tap reset by test reset low or five mode-select highs loads idcode.
// - Id bit zero is one, so the first bit out after reset is one.
// - Bypass exists besides id and is not the default after reset.
// - Idcode in Shift-DR shifts 32 bits out, least significant first.
// - Id is read-only: maker 11:1, part 27:12, revision 31:28.
// - Capture-IR loads the capture pattern whose low bits are 01.
// - Instruction bits shift into six bits and latch only at Update-IR.
// - Instruction codes are fixed; all others reserved.
`timescale 1ns/1ps
`include "jtbi_defs.svh"
module jtbi_tap
  import jtbi_pkg::*;
#(
  parameter logic [10:0] MAKER_CODE = 11'h155, // Arbitrary value
  parameter logic [15:0] PART_CODE = 16'h1234, // Arbitrary value
  parameter logic [3:0] REVISION = 4'h1 // Arbitrary value
)(
  input wire logic mclk_in, // 40 MHz system clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic tck_in, // Test clock pin
  input wire logic tms_in, // Mode select pin
  input wire logic tdi_in, // Data in pin
  input wire logic trst_n_in, // Test reset pin, active low
  output logic tdo_out, // Data out pin
  output logic tdo_oe_out, // Data out enable, high drives
  output logic clamp_out, // Clamp active
  output logic highz_out, // Highz active
  output logic extest_out, // Extest active
  output logic [5:0] instr_out, // Current instruction
  output logic [3:0] state_out // Controller state
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  jtbi_pins_t pins;
  logic trst_n;
  jtbi_state_t st_q, st_d;
  logic [5:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
  logic [31:0] dr_q, dr_d;
  logic byp_q, byp_d;
  logic tdo_q, tdo_d, oe_q, oe_d;
  logic clamp_q, clamp_d, highz_q, highz_d, ext_q, ext_d;
  jtbi_id_t id_word;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_q[1];

  jtbi_pin_sync u_sync (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .tck_in(tck_in),
    .tms_in(tms_in),
    .tdi_in(tdi_in),
    .trst_n_in(trst_n_in),
    .pins_out(pins),
    .trst_n_out(trst_n)
  );

  always_comb begin
    id_word.revision = REVISION;
    id_word.part_code = PART_CODE;
    id_word.maker_code_field = MAKER_CODE;
    id_word.marker = `JTBI_ID_MARKER;
  end

  function automatic jtbi_state_t next_state(input jtbi_state_t s, input logic m);
    unique case (s)
      JTBI_RESET: next_state = m ? JTBI_RESET : JTBI_IDLE;
      JTBI_IDLE: next_state = m ? JTBI_SEL_DR : JTBI_IDLE;
      JTBI_SEL_DR: next_state = m ? JTBI_SEL_IR : JTBI_CAP_DR;
      JTBI_CAP_DR: next_state = m ? JTBI_EX1_DR : JTBI_SH_DR;
      JTBI_SH_DR: next_state = m ? JTBI_EX1_DR : JTBI_SH_DR;
      JTBI_EX1_DR: next_state = m ? JTBI_UPD_DR : JTBI_PA_DR;
      JTBI_PA_DR: next_state = m ? JTBI_EX2_DR : JTBI_PA_DR;
      JTBI_EX2_DR: next_state = m ? JTBI_UPD_DR : JTBI_SH_DR;
      JTBI_UPD_DR: next_state = m ? JTBI_SEL_DR : JTBI_IDLE;
      JTBI_SEL_IR: next_state = m ? JTBI_RESET : JTBI_CAP_IR;
      JTBI_CAP_IR: next_state = m ? JTBI_EX1_IR : JTBI_SH_IR;
      JTBI_SH_IR: next_state = m ? JTBI_EX1_IR : JTBI_SH_IR;
      JTBI_EX1_IR: next_state = m ? JTBI_UPD_IR : JTBI_PA_IR;
      JTBI_PA_IR: next_state = m ? JTBI_EX2_IR : JTBI_PA_IR;
      JTBI_EX2_IR: next_state = m ? JTBI_UPD_IR : JTBI_SH_IR;
      JTBI_UPD_IR: next_state = m ? JTBI_SEL_DR : JTBI_IDLE;
    endcase
  endfunction : next_state

  // Id path only for idcode; all other codes fall to bypass
  function automatic logic sel_id(input logic [5:0] ins);
    sel_id = (ins == `JTBI_INS_IDCODE);
  endfunction : sel_id

  always_comb begin
    st_d = st_q;
    ir_sh_d = ir_sh_q;
    ir_d = ir_q;
    dr_d = dr_q;
    byp_d = byp_q;
    tdo_d = tdo_q;
    oe_d = oe_q;
    if (!trst_n) begin
      st_d = JTBI_RESET;
      ir_d = `JTBI_INS_IDCODE;
      oe_d = 1'h0;
    end else if (pins.tck_rise) begin
      st_d = next_state(st_q, pins.tms);
      unique case (st_q)
        JTBI_RESET: ir_d = `JTBI_INS_IDCODE;
        // Idcode loads as the state enters reset, not one tck later
        JTBI_SEL_IR: begin
          if (pins.tms) begin
            ir_d = `JTBI_INS_IDCODE;
          end
        end
        JTBI_CAP_IR: ir_sh_d = `JTBI_INS_CAPTURE;
        JTBI_SH_IR: ir_sh_d = {pins.tdi, ir_sh_q[5:1]};
        JTBI_UPD_IR: ir_d = ir_sh_q;
        JTBI_CAP_DR: begin
          dr_d = id_word;
          byp_d = 1'h0;
        end
        JTBI_SH_DR: begin
          dr_d = {pins.tdi, dr_q[31:1]};
          byp_d = pins.tdi;
        end
        default: ;
      endcase
    end else if (pins.tck_fall) begin
      oe_d = (st_q == JTBI_SH_DR) || (st_q == JTBI_SH_IR);
      if (st_q == JTBI_SH_IR) begin
        tdo_d = ir_sh_q[0];
      end else if (st_q == JTBI_SH_DR) begin
        tdo_d = sel_id(ir_q) ? dr_q[0] : byp_q;
      end
    end
  end

  // Five tck with tms high always reach reset through the state graph
  always_comb begin
    clamp_d = (ir_q == `JTBI_INS_CLAMP);
    highz_d = (ir_q == `JTBI_INS_HIGHZ);
    ext_d = (ir_q == `JTBI_INS_EXTEST);
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= JTBI_RESET;
      ir_sh_q <= 6'h00;
      ir_q <= `JTBI_INS_IDCODE;
      dr_q <= 32'h00000000;
      byp_q <= 1'h0;
      tdo_q <= 1'h0;
      oe_q <= 1'h0;
      clamp_q <= 1'h0;
      highz_q <= 1'h0;
      ext_q <= 1'h0;
    end else begin
      st_q <= st_d;
      ir_sh_q <= ir_sh_d;
      ir_q <= ir_d;
      dr_q <= dr_d;
      byp_q <= byp_d;
      tdo_q <= tdo_d;
      oe_q <= oe_d;
      clamp_q <= clamp_d;
      highz_q <= highz_d;
      ext_q <= ext_d;
    end
  end

  always_comb begin
    tdo_out = tdo_q;
    tdo_oe_out = oe_q;
    clamp_out = clamp_q;
    highz_out = highz_q;
    extest_out = ext_q;
    instr_out = ir_q;
    state_out = st_q;
  end
endmodule : jtbi_tap

// File: verif/jtbi_tap_checker.sv
// Purpose: port-level checks of the tap block
// Assumes: flags lag instr_out by one mclk
// Notes: bound to jtbi_tap
`timescale 1ns/1ps
`include "jtbi_defs.svh"
module jtbi_tap_checker
  import jtbi_pkg::*;
(
  input wire logic mclk_in, // Clock
  input wire logic rst_n_in, // Reset
  input wire logic trst_n_in, // Test reset
  input wire logic tdo_oe_out, // Data out enable
  input wire logic clamp_out, // Clamp flag
  input wire logic highz_out, // Highz flag
  input wire logic extest_out, // Extest flag
  input wire logic [5:0] instr_out, // Instruction
  input wire logic [3:0] state_out // State
);
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  a_oe_shift:
    assert property (tdo_oe_out |-> state_out inside {JTBI_SH_DR, JTBI_EX1_DR, JTBI_SH_IR,
      JTBI_EX1_IR}) else $error("data out enabled outside shift");
  a_clamp_flag:
    assert property (clamp_out == ($past(instr_out) == `JTBI_INS_CLAMP))
      else $error("clamp flag wrong");
  a_highz_flag:
    assert property (highz_out == ($past(instr_out) == `JTBI_INS_HIGHZ))
      else $error("highz flag wrong");
  a_extest_flag:
    assert property (extest_out == ($past(instr_out) == `JTBI_INS_EXTEST))
      else $error("extest flag wrong");
  a_trst_idcode:
    assert property (!trst_n_in [*5] |-> state_out == JTBI_RESET &&
      instr_out == `JTBI_INS_IDCODE) else $error("test reset ignored");
  a_instr_upd:
    assert property ($changed(instr_out) |-> state_out inside {JTBI_UPD_IR, JTBI_RESET} ||
      $past(state_out) == JTBI_UPD_IR) else $error("instruction changed early");
  a_capir_next:
    assert property ($changed(state_out) && $past(state_out) == JTBI_CAP_IR |->
      state_out inside {JTBI_SH_IR, JTBI_EX1_IR, JTBI_RESET}) else $error("bad capture exit");
  a_reset_exit:
    assert property ($changed(state_out) && $past(state_out) == JTBI_RESET |->
      state_out == JTBI_IDLE) else $error("bad reset exit");
endmodule : jtbi_tap_checker
bind jtbi_tap jtbi_tap_checker chk_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .trst_n_in(trst_n_in), .tdo_oe_out(tdo_oe_out), .clamp_out(clamp_out),
  .highz_out(highz_out), .extest_out(extest_out), .instr_out(instr_out),
  .state_out(state_out));

// File: verif/jtbi_tester.sv
// Purpose: board tester model driving the tap pins
// Assumes: 9 mclk per test clock period
// Notes: test clock stands low between steps
`timescale 1ns/1ps
module jtbi_tester (
  input wire logic clk_in, // System clock
  input wire logic tdo_in, // Device data out
  input wire logic tdo_oe_in, // Device data out enable
  output logic tck_out, // Test clock
  output logic tms_out, // Mode select
  output logic tdi_out, // Data in
  output logic trst_n_out // Test reset
);
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
    trst_n_out = 1'b0;
  end
  task automatic trst(input logic v);
    @(posedge clk_in);
    trst_n_out <= v;
    repeat (4) @(posedge clk_in);
  endtask : trst
  task automatic step(input logic ms, input logic di, output logic so);
    @(posedge clk_in);
    tms_out <= ms;
    tdi_out <= di;
    repeat (4) @(posedge clk_in);
    tck_out <= 1'b1;
    repeat (2) @(posedge clk_in);
    // Released pin reads as the inverse of its last value
    so = tdo_oe_in ? tdo_in : ~tdo_in;
    repeat (2) @(posedge clk_in);
    tck_out <= 1'b0;
  endtask : step
endmodule : jtbi_tester

// File: verif/test_jtag_tap_bypass_idcode_logic.sv
// Purpose: self-checking bench of the tap block
// Assumes: tester model owns the pins
// Notes: id fields set to arbitrary values
`timescale 1ns/1ps
`include "jtbi_defs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module test_jtag_tap_bypass_idcode_logic;
  localparam logic [31:0] ID = {4'h9, 16'h5A5A, 11'h2AA, 1'h1}; // Arbitrary
  logic mclk, rst_n, tck, tms, tdi, trst_n, tdo, oe, clamp, highz, extest, b;
  logic [5:0] instr;
  logic [3:0] state;
  logic [31:0] d;
  logic [5:0] codes [7] = '{6'h00, 6'h01, 6'h03, 6'h2D, 6'h3E, 6'h02, 6'h3F};
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  jtbi_tap #(.MAKER_CODE(11'h2AA), .PART_CODE(16'h5A5A), .REVISION(4'h9)) jtbi_tap_i (
    .mclk_in(mclk), .rst_n_in(rst_n), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .trst_n_in(trst_n), .tdo_out(tdo), .tdo_oe_out(oe), .clamp_out(clamp),
    .highz_out(highz), .extest_out(extest), .instr_out(instr), .state_out(state));
  jtbi_tester jtbi_tester_i (.clk_in(mclk), .tdo_in(tdo), .tdo_oe_in(oe), .tck_out(tck),
    .tms_out(tms),
    .tdi_out(tdi), .trst_n_out(trst_n));
  task automatic finish_test;
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic scan(input logic ir, input logic [31:0] din, input int n);
    d = '0;
    jtbi_tester_i.step(1'b1, 1'b1, b);
    if (ir) jtbi_tester_i.step(1'b1, 1'b1, b);
    repeat (2) jtbi_tester_i.step(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      jtbi_tester_i.step(i == n - 1, din[i], b);
      d[i] = b;
    end
    jtbi_tester_i.step(1'b1, 1'b1, b);
    jtbi_tester_i.step(1'b0, 1'b1, b);
    @(negedge mclk);
  endtask : scan
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    jtbi_tester_i.trst(1'b1);
    `CHK(instr, `JTBI_INS_IDCODE)
    jtbi_tester_i.step(1'b0, 1'b1, b);
    scan(1'b0, 32'h0, 32);
    `CHK(d, ID)
    scan(1'b1, 32'h3F, 6);
    `CHK(d[5:0], `JTBI_INS_CAPTURE)
    `CHK(instr, `JTBI_INS_BYPASS)
    scan(1'b0, 32'h5, 3);
    `CHK(d[2:0], 3'h2)
    foreach (codes[k]) begin
      scan(1'b1, {26'h0, codes[k]}, 6);
      `CHK(instr, codes[k])
      `CHK({extest, highz, clamp}, {codes[k] == 6'h00, codes[k] == 6'h03, codes[k] == 6'h3E})
      scan(1'b0, 32'h1, 2);
      `CHK(d[1:0], (codes[k] == `JTBI_INS_IDCODE) ? ID[1:0] : 2'h2)
    end
    repeat (5) jtbi_tester_i.step(1'b1, 1'b1, b);
    @(negedge mclk);
    `CHK({state, instr}, {4'h0, `JTBI_INS_IDCODE})
    jtbi_tester_i.step(1'b0, 1'b1, b);
    scan(1'b1, 32'h3E, 6);
    jtbi_tester_i.trst(1'b0);
    `CHK({state, instr}, {4'h0, `JTBI_INS_IDCODE})
    finish_test();
  end
endmodule : test_jtag_tap_bypass_idcode_logic
